// ---- core/plc_pkg.sv ----
// Constants and types for the 32-line I/O controller slice.
// Assumes a 32-bit AHB-Lite bus and one 50 MHz system clock.
package plc_pkg;

  localparam int unsigned NUM_LINES = 32;
  localparam int unsigned ADDR_W    = 8;

  // Word offsets of the register map
  localparam logic [7:0] OFS_PIN_LEVEL_READBACK  = 8'h00;
  localparam logic [7:0] OFS_OUTPUT_DATA_VALUE   = 8'h04;
  localparam logic [7:0] OFS_CHANGE_IRQ_ENABLE   = 8'h08;
  localparam logic [7:0] OFS_CHANGE_IRQ_DISABLE  = 8'h0c;
  localparam logic [7:0] OFS_CHANGE_IRQ_MASK     = 8'h10;
  localparam logic [7:0] OFS_CHANGE_IRQ_STATUS   = 8'h14;
  localparam logic [7:0] OFS_OPEN_DRAIN_ENABLE   = 8'h18;
  localparam logic [7:0] OFS_OPEN_DRAIN_DISABLE  = 8'h1c;
  localparam logic [7:0] OFS_OPEN_DRAIN_STATUS   = 8'h20;
  localparam logic [7:0] OFS_PULLUP_DISABLE      = 8'h24;
  localparam logic [7:0] OFS_PULLUP_ENABLE       = 8'h28;
  localparam logic [7:0] OFS_PULLUP_STATUS       = 8'h2c;
  localparam logic [7:0] OFS_PERIPH_FIRST_SELECT = 8'h30;
  localparam logic [7:0] OFS_PERIPH_SECOND_SEL   = 8'h34;
  localparam logic [7:0] OFS_PERIPH_SELECT_STAT  = 8'h38;
  localparam logic [7:0] OFS_DIRECT_WRITE_ENABLE = 8'h3c;
  localparam logic [7:0] OFS_DIRECT_WRITE_DISABL = 8'h40;
  localparam logic [7:0] OFS_DIRECT_WRITE_STATUS = 8'h44;

  // Reset values
  localparam logic [31:0] RST_LINES     = 32'h0000_0000;
  localparam logic [31:0] RST_OUT_DATA  = 32'h0000_0000;
  localparam logic [31:0] RST_IRQ_MASK  = 32'h0000_0000;
  localparam logic [31:0] RST_OPEN_DR   = 32'h0000_0000;
  localparam logic [31:0] RST_PULLUP_ST = 32'h0000_0000;
  localparam logic [31:0] RST_PERIPH_ST = 32'h0000_0000;
  localparam logic [31:0] RST_DIRECT_WR = 32'h0000_0000;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // Bus slave states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_WRITE = 4'h2,
    ST_READ  = 4'h4,
    ST_RDONE = 4'h8
  } plc_bus_state_t;

  // Per-line drive toward the pads
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
    logic [31:0] pullup_en;
    logic [31:0] periph_second;
  } plc_pad_t;

  // One AHB address phase, held for its data phase
  typedef struct packed {
    logic [7:0] addr;
    logic       write;
  } plc_addr_t;

endpackage

// ---- core/plc_top.sv ----
// 32-line I/O controller slice: change interrupts, open-drain drive,
// pull-ups, peripheral select and gated direct output writes.
// Assumes one AHB-Lite master, single word transfers, pad inputs
// asynchronous to i_clk_sys, output enable supplied by other logic.
//
// Summary of operation
// - Pin level readback shows each line's sampled level, 1 high, 0 low.
// - Writing 1 to change_irq_enable enables that line's change interrupt.
// - Writing 1 to change_irq_disable disables that line's change interrupt.
// - change_irq_mask reads 1 for enabled lines, 0 for disabled.
// - A status bit sets on any level change since last read or reset.
// - Reading change_irq_status clears it; reset clears it too.
// - Writing 1 to open_drain_enable makes the line open-drain; 0 no effect.
// - Writing 1 to open_drain_disable returns the line to push-pull.
// - Open-drain lines drive low only; others drive high and low.
// - Writing 1 to pullup_disable switches that line's pull-up off.
// - Writing 1 to pullup_enable switches that line's pull-up on.
// - pullup_status reads 0 when enabled, 1 when disabled.
// - Writing 1 to periph_first_select routes the line to function one.
// - Writing 1 to periph_second_select routes the line to function two.
// - periph_select_status reads 0 for first, 1 for second function.
// - Direct output writes update only lines whose write gate is 1.
// - direct_write_enable sets the gate, direct_write_disable clears it.
//
// Local design decisions: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns

module plc_top
  import plc_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_reset_n,
  // AHB-Lite slave
  input  wire logic              i_hsel,
  input  wire logic [31:0]       i_haddr,
  input  wire logic [1:0]        i_htrans,
  input  wire logic              i_hwrite,
  input  wire logic [2:0]        i_hsize,
  input  wire logic [31:0]       i_hwdata,
  input  wire logic              i_hready,
  output logic      [31:0]       o_hrdata,
  output logic                   o_hreadyout,
  output logic                   o_hresp,
  // Pads and peripheral routing
  input  wire logic [31:0]       i_pad_in,
  input  wire logic [31:0]       i_line_out_en,
  output plc_pad_t               o_pad,
  // Interrupt
  output logic                   o_irq
);

  // Set and clear with set-on-one, clear-on-one semantics
  function automatic logic [31:0] f_setclr(input logic [31:0] cur,
                                           input logic [31:0] set,
                                           input logic [31:0] clr);
    f_setclr = (cur | set) & ~clr;
  endfunction

  // Write strobe for one register offset
  function automatic logic [31:0] f_wstb(input logic        we,
                                         input logic [7:0]  addr,
                                         input logic [7:0]  ofs,
                                         input logic [31:0] data);
    f_wstb = (we && addr == ofs) ? data : 32'h0000_0000;
  endfunction

  plc_bus_state_t state;
  plc_bus_state_t next_state;
  plc_addr_t      aphase;
  plc_pad_t       next_pad;

  logic [31:0] sync_a;
  logic [31:0] pin_level_readback;
  logic [31:0] pin_prev;
  logic [31:0] output_data_value;
  logic [31:0] change_irq_mask;
  logic [31:0] change_irq_status;
  logic [31:0] open_drain_status;
  logic [31:0] pullup_status;
  logic [31:0] periph_select_status;
  logic [31:0] direct_write_status;

  // Bus decode
  wire        take     = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);
  wire        we       = (state == ST_WRITE);
  wire        rd_load  = (state == ST_READ);
  wire [7:0]  wa       = aphase.addr;
  wire [31:0] wd       = i_hwdata;

  wire [31:0] w_irq_on     = f_wstb(we, wa, OFS_CHANGE_IRQ_ENABLE, wd);
  wire [31:0] w_irq_off    = f_wstb(we, wa, OFS_CHANGE_IRQ_DISABLE, wd);
  wire [31:0] w_od_on      = f_wstb(we, wa, OFS_OPEN_DRAIN_ENABLE, wd);
  wire [31:0] w_od_off     = f_wstb(we, wa, OFS_OPEN_DRAIN_DISABLE, wd);
  wire [31:0] w_pu_off     = f_wstb(we, wa, OFS_PULLUP_DISABLE, wd);
  wire [31:0] w_pu_on      = f_wstb(we, wa, OFS_PULLUP_ENABLE, wd);
  wire [31:0] w_sel_first  = f_wstb(we, wa, OFS_PERIPH_FIRST_SELECT, wd);
  wire [31:0] w_sel_second = f_wstb(we, wa, OFS_PERIPH_SECOND_SEL, wd);
  wire [31:0] w_gate_on    = f_wstb(we, wa, OFS_DIRECT_WRITE_ENABLE, wd);
  wire [31:0] w_gate_off   = f_wstb(we, wa, OFS_DIRECT_WRITE_DISABL, wd);
  // Status also clears by writing one
  wire [31:0] w_stat_clr   = f_wstb(we, wa, OFS_CHANGE_IRQ_STATUS, wd);
  wire        w_data       = we && (wa == OFS_OUTPUT_DATA_VALUE);

  // level change detect on synchronised level
  wire [31:0] change   = pin_level_readback ^ pin_prev;
  // clear on read of the status word
  wire        rd_stat  = rd_load && (aphase.addr == OFS_CHANGE_IRQ_STATUS);
  wire [31:0] stat_clr = {NUM_LINES{rd_stat}} | w_stat_clr;

  // zero bits leave settings as they are
  wire [31:0] next_mask  = f_setclr(change_irq_mask, w_irq_on, w_irq_off);
  wire [31:0] next_drain = f_setclr(open_drain_status, w_od_on, w_od_off);
  wire [31:0] next_pull  = f_setclr(pullup_status, w_pu_off, w_pu_on);
  wire [31:0] next_route = f_setclr(periph_select_status, w_sel_second,
                                    w_sel_first);
  wire [31:0] next_gate  = f_setclr(direct_write_status, w_gate_on,
                                    w_gate_off);
  // Set wins over clear so no change is lost
  wire [31:0] next_stat  = (change_irq_status & ~stat_clr) | change;

  wire [31:0] next_data = w_data ? ((output_data_value & ~direct_write_status)
                                   | (wd & direct_write_status))
                                 : output_data_value;

  wire        next_irq  = |(next_stat & next_mask);

  // Read multiplexer
  logic [31:0] rd_mux;
  always_comb
  begin
    case (aphase.addr)
      OFS_PIN_LEVEL_READBACK:  rd_mux = pin_level_readback;
      OFS_OUTPUT_DATA_VALUE:   rd_mux = output_data_value;
      OFS_CHANGE_IRQ_MASK:     rd_mux = change_irq_mask;
      OFS_CHANGE_IRQ_STATUS:   rd_mux = change_irq_status;
      OFS_OPEN_DRAIN_STATUS:   rd_mux = open_drain_status;
      OFS_PULLUP_STATUS:       rd_mux = pullup_status;
      OFS_PERIPH_SELECT_STAT:  rd_mux = periph_select_status;
      OFS_DIRECT_WRITE_STATUS: rd_mux = direct_write_status;
      default:                 rd_mux = READ_UNMAPPED;
    endcase
  end

  // Reads take one wait state so a write just before is visible
  always_comb
  begin
    case (state)
      ST_IDLE, ST_WRITE, ST_RDONE:
        if (take)
          next_state = i_hwrite ? ST_WRITE : ST_READ;
        else
          next_state = ST_IDLE;
      ST_READ:  next_state = ST_RDONE;
      default:  next_state = ST_IDLE;
    endcase
  end

  // open-drain lines only ever pull low
  always_comb
  begin
    next_pad.out           = next_data & ~next_drain;
    next_pad.oe            = i_line_out_en & ~(next_drain & next_data);
    next_pad.pullup_en     = ~next_pull;
    next_pad.periph_second = next_route;
  end

  // Two-flop pad synchroniser; pin_prev feeds change detect
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sync_a             <= RST_LINES;
      pin_level_readback <= RST_LINES;
      pin_prev           <= RST_LINES;
    end
    else
    begin
      sync_a             <= i_pad_in;
      pin_level_readback <= sync_a;
      pin_prev           <= pin_level_readback;
    end
  end

  // Bus slave
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state       <= ST_IDLE;
      aphase      <= '0;
      o_hrdata    <= READ_UNMAPPED;
      o_hreadyout <= 1'b1;
      o_hresp     <= HRESP_OKAY;
    end
    else
    begin
      state       <= next_state;
      o_hresp     <= HRESP_OKAY;
      o_hreadyout <= (next_state != ST_READ);
      if (take)
        aphase <= '{addr: i_haddr[7:0], write: i_hwrite};
      if (rd_load)
        o_hrdata <= rd_mux;
    end
  end

  // Line settings
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      output_data_value    <= RST_OUT_DATA;
      change_irq_mask      <= RST_IRQ_MASK;
      change_irq_status    <= RST_LINES;
      open_drain_status    <= RST_OPEN_DR;
      pullup_status        <= RST_PULLUP_ST;
      periph_select_status <= RST_PERIPH_ST;
      direct_write_status  <= RST_DIRECT_WR;
    end
    else
    begin
      output_data_value    <= next_data;
      change_irq_mask      <= next_mask;
      change_irq_status    <= next_stat;
      open_drain_status    <= next_drain;
      pullup_status        <= next_pull;
      periph_select_status <= next_route;
      direct_write_status  <= next_gate;
    end
  end

  // Pads and interrupt leave straight from flops
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_pad <= '{out: RST_LINES, oe: RST_LINES,
                 pullup_en: ~RST_PULLUP_ST, periph_second: RST_PERIPH_ST};
      o_irq <= 1'b0;
    end
    else
    begin
      o_pad <= next_pad;
      o_irq <= next_irq;
    end
  end

endmodule

// ---- dv/plc_top_properties.sv ----
// Checker on plc_top ports, bound into every plc_top instance.
// Assumes one AHB master with hready fed back from hreadyout.
`timescale 1ns/1ns
module plc_top_checker
  import plc_pkg::*;
(
  // Clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_reset_n,
  // Bus
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  // Pads and interrupt
  input wire logic [31:0] i_pad_in,
  input wire logic [31:0] i_line_out_en,
  input wire plc_pad_t    o_pad,
  input wire logic        o_irq
);
  logic rd_go;
  logic wr_go;
  assign rd_go = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ && !i_hwrite;
  assign wr_go = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ && i_hwrite;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  // A read costs exactly one wait state
  sequence s_rd_wait;
    !o_hreadyout ##1 o_hreadyout;
  endsequence
  // Pads steady long enough that no change sits in the synchroniser
  sequence s_quiet_rd;
    $stable(i_pad_in) [*5] ##0
      (rd_go && i_haddr[7:0] == OFS_CHANGE_IRQ_STATUS)
      ##1 $stable(i_pad_in) [*2];
  endsequence

  a_resp_okay: assert property (o_hresp == HRESP_OKAY)
    else $error("bus response not okay");
  a_read_wait: assert property (rd_go |=> s_rd_wait)
    else $error("read wait state wrong");
  a_rdata_hold: assert property ($changed(o_hrdata) |-> !$past(o_hreadyout))
    else $error("read data moved outside a read");
  a_oe_gated:
    assert property ((o_pad.oe & ~$past(i_line_out_en)) == 32'h0)
    else $error("line driven without outside enable");
  a_out_by_write:
    assert property ($changed(o_pad.out) |-> $past(wr_go, 2))
    else $error("output moved without a write");
  a_pull_by_write:
    assert property ($changed(o_pad.pullup_en) |-> $past(wr_go, 2))
    else $error("pull-up moved without a write");
  a_route_by_write:
    assert property ($changed(o_pad.periph_second) |-> $past(wr_go, 2))
    else $error("routing moved without a write");
  a_irq_cleared:
    assert property (s_quiet_rd |=> !o_irq)
    else $error("interrupt stayed up after status read");
endmodule

bind plc_top plc_top_checker i_chk (.*);

// ---- dv/plc_pad_model.sv ----
// Pad model: resolves each line from controller drive or outside source.
// Assumes an outside source drives every line the controller releases.
`timescale 1ns/1ns
module plc_pad_model
  import plc_pkg::*;
(
  // Controller drive
  input  wire plc_pad_t    i_pad,
  // Outside source
  input  wire logic [31:0] i_ext_val,
  // Resolved level
  output logic      [31:0] o_level
);
  assign o_level = (i_pad.oe & i_pad.out) | (~i_pad.oe & i_ext_val);
endmodule

// ---- dv/test_plc_top.sv ----
// Bench for plc_top: register access over AHB-Lite and change interrupts.
// Assumes the pad model feeds each resolved line level back to the pads.
`timescale 1ns/1ns
module test_plc_top
  import plc_pkg::*;
();
  localparam logic WR = 1'b1;
  localparam logic RD = 1'b0;
  logic        clk_sys, reset_n, hsel, hwrite, hready, irq;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, line_out_en, ext_val, level;
  plc_pad_t    pad;
  int          err_count = 0;
  int          checks = 0;
  logic [7:0]  ofs [8] = '{OFS_CHANGE_IRQ_MASK, OFS_CHANGE_IRQ_STATUS,
    OFS_OPEN_DRAIN_STATUS, OFS_PULLUP_STATUS, OFS_PERIPH_SELECT_STAT,
    OFS_DIRECT_WRITE_STATUS, OFS_CHANGE_IRQ_ENABLE, 8'h80};

  plc_top i_dut (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(), .i_pad_in(level),
    .i_line_out_en(line_out_en), .o_pad(pad), .o_irq(irq));
  plc_pad_model i_pads (.i_pad(pad), .i_ext_val(ext_val), .o_level(level));

  task automatic close_out(input int lost);
    err_count += lost;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait so a stuck slave ends the run instead of hanging it
  task automatic edge_rdy();
    int n = 0;
    do @(posedge clk_sys); while (hready !== 1'b1 && ++n < 64);
    if (n >= 64)
      close_out(1);
  endtask

  // A write sends d, a read compares its data with d
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    edge_rdy();
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    edge_rdy();
    if (!w)
      chk(hrdata, d);
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial
  begin
    reset_n     = 1'b0;
    hsel        = 1'b0;
    hwrite      = 1'b0;
    htrans      = 2'h0;
    haddr       = 32'h0;
    hwdata      = 32'h0;
    line_out_en = 32'hffff_ffff;
    ext_val     = 32'h0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    foreach (ofs[i]) bus(RD, ofs[i], 32'h0);
    chk(pad.pullup_en, 32'hffff_ffff);
    $display("test reset done");
    bus(WR, OFS_CHANGE_IRQ_ENABLE, 32'hff);
    bus(RD, OFS_CHANGE_IRQ_MASK, 32'hff);
    bus(WR, OFS_CHANGE_IRQ_DISABLE, 32'he);
    bus(WR, OFS_CHANGE_IRQ_ENABLE, 32'h0);
    bus(RD, OFS_CHANGE_IRQ_MASK, 32'hf1);
    bus(WR, OFS_OPEN_DRAIN_ENABLE, 32'h3);
    bus(WR, OFS_OPEN_DRAIN_DISABLE, 32'h1);
    bus(RD, OFS_OPEN_DRAIN_STATUS, 32'h2);
    bus(WR, OFS_OUTPUT_DATA_VALUE, 32'hffff_ffff);
    bus(RD, OFS_OUTPUT_DATA_VALUE, 32'h0);
    bus(WR, OFS_DIRECT_WRITE_ENABLE, 32'hffff);
    bus(WR, OFS_DIRECT_WRITE_DISABL, 32'hf0);
    bus(RD, OFS_DIRECT_WRITE_STATUS, 32'hff0f);
    bus(WR, OFS_OUTPUT_DATA_VALUE, 32'hffff_ffff);
    bus(RD, OFS_OUTPUT_DATA_VALUE, 32'hff0f);
    chk(pad.out, 32'hff0d);
    chk(pad.oe, 32'hffff_fffd);
    $display("test drive done");
    bus(WR, OFS_PULLUP_DISABLE, 32'hf0);
    bus(WR, OFS_PULLUP_ENABLE, 32'h30);
    bus(RD, OFS_PULLUP_STATUS, 32'hc0);
    chk(pad.pullup_en, 32'hffff_ff3f);
    bus(WR, OFS_PERIPH_SECOND_SEL, 32'h5);
    bus(WR, OFS_PERIPH_FIRST_SELECT, 32'h1);
    bus(RD, OFS_PERIPH_SELECT_STAT, 32'h4);
    chk(pad.periph_second, 32'h4);
    $display("test setup done");
    line_out_en <= 32'h0;
    repeat (8) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    bus(RD, OFS_CHANGE_IRQ_STATUS, 32'hff0d);
    bus(RD, OFS_CHANGE_IRQ_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    ext_val <= 32'h100;
    repeat (5) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    ext_val <= 32'h101;
    repeat (5) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    bus(RD, OFS_PIN_LEVEL_READBACK, 32'h101);
    bus(RD, OFS_CHANGE_IRQ_STATUS, 32'h101);
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    $display("test change done");
    ext_val <= 32'h0;
    repeat (5) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    reset_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    bus(RD, OFS_CHANGE_IRQ_STATUS, 32'h0);
    bus(RD, OFS_CHANGE_IRQ_MASK, 32'h0);
    $display("test mid-run reset done");
    close_out(0);
  end
endmodule
